// file: utsc_core.sv
// serial transmitter and receiver with status flags and interrupts
`timescale 1ns/1ns
`include "utsc_map.svh"
module utsc_core import utsc_pkg::*; (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // configuration
  input  wire logic [6:0] serial_control_register,
  input  wire logic [7:0] serial_mode_register,
  input  wire logic [7:0] baud_rate_generator,
  // transmit buffer writes
  input  wire logic       buffer_low_byte_wr,
  input  wire logic [7:0] buffer_low_byte_in,
  input  wire logic       buffer_high_byte_wr,
  input  wire logic       buffer_high_byte_in,
  // receive buffer and status reads
  input  wire logic       buffer_low_byte_rd,
  input  wire logic       status_rd,
  output logic [8:0]      receive_buffer,
  output logic [7:0]      serial_status_register,
  // interrupt requests
  output logic            transmit_interrupt,
  output logic            receive_full_interrupt,
  output logic            receive_error_interrupt,
  // serial pins
  input  wire logic       receive_data_input,
  input  wire logic       clear_to_send_input,
  output logic            transmit_data_output,
  output logic            request_to_send_output
);
  // control and mode decode
  logic       transmit_enable_bit;
  logic       ren;
  logic       transmitter_init_bit;
  logic       receiver_init_bit;
  logic       transmit_interrupt_select;
  logic       cts_en;
  logic       rts_en;
  logic       stb;
  logic       parity_select;
  logic       parity_enable;
  logic [3:0] data_len;
  logic       tick16;

  assign transmit_enable_bit      = serial_control_register[`CTL_TEN];
  assign ren      = serial_control_register[`CTL_REN];
  assign transmitter_init_bit      = serial_control_register[`CTL_TIN];
  assign receiver_init_bit      = serial_control_register[`CTL_RIN];
  assign transmit_interrupt_select      = serial_control_register[`CTL_TIS];
  assign cts_en   = serial_control_register[`CTL_CTS];
  assign rts_en   = serial_control_register[`CTL_RTS];
  assign stb      = serial_mode_register[`MOD_STB];
  assign parity_select      = serial_mode_register[`MOD_PMD];
  assign parity_enable      = serial_mode_register[`MOD_PEN];
  assign data_len = utsc_data_len(
    serial_mode_register[`MOD_LEN_HI:`MOD_LEN_LO]);

  // pins cross into the clock domain through two flops
  logic rxd_s1_q;
  logic rxd_s2_q;
  logic cts_s1_q;
  logic cts_s2_q;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
      cts_s1_q <= 1'b1;
      cts_s2_q <= 1'b1;
    end else begin
      rxd_s1_q <= receive_data_input;
      rxd_s2_q <= rxd_s1_q;
      cts_s1_q <= clear_to_send_input;
      cts_s2_q <= cts_s1_q;
    end
  end

  utsc_baud u_baud (
    .clk_sys (clk_sys),
    .reset   (reset),
    .psc_sel (serial_mode_register[`MOD_PSC_HI:`MOD_PSC_LO]),
    .divisor (baud_rate_generator),
    .tick16  (tick16)
  );

  // ---------------- transmit side
  utsc_tx_state_type tx_state_q;
  logic [8:0]  tx_buf_q;
  logic [12:0] tx_frame_q;
  logic [12:0] tx_frame_w;
  logic [3:0]  tx_left_q;
  logic [3:0]  tx_ph_q;
  logic [3:0]  tx_len_w;
  logic        tbe_q;
  logic        tcm_q;
  logic        tx_irq_q;
  logic        tx_par;
  logic        cts_ok;
  logic        can_load;
  logic        bit_end;
  logic        last_end;
  logic        load;
  logic        tcm_set;

  // a load is held off in the write cycle so no character is lost
  assign tx_par   = utsc_parity(tx_buf_q, data_len, parity_select);
  assign cts_ok   = ~cts_en | ~cts_s2_q;
  assign can_load = ~tbe_q & transmit_enable_bit & cts_ok & ~buffer_low_byte_wr & ~transmitter_init_bit;
  assign bit_end  = (tx_state_q == TX_SHIFT) & tick16
                    & (tx_ph_q == `PHASE_LAST);
  assign last_end = bit_end & (tx_left_q == 4'h1);
  assign load     = ((tx_state_q == TX_IDLE) | last_end) & can_load;
  assign tcm_set  = last_end & ~can_load;
  assign tx_len_w = 4'h2 + data_len + {3'h0, parity_enable} + {3'h0, stb};

  // frame image: start, data LSB first, parity, stop ones above
  always_comb begin
    tx_frame_w    = '1;
    tx_frame_w[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < data_len) tx_frame_w[i + 1] = tx_buf_q[i];
    end
    if (parity_enable) tx_frame_w[data_len + 4'h1] = tx_par;
  end

  // transmit buffer, high bit written first by software
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tx_buf_q <= 9'h000;
    end else begin
      if (buffer_low_byte_wr) tx_buf_q[7:0] <= buffer_low_byte_in;
      if (buffer_high_byte_wr) tx_buf_q[8] <= buffer_high_byte_in;
    end
  end

  // shifter and transmit flags; enable changes never cut a frame
  always_ff @(posedge clk_sys) begin
    if (reset || transmitter_init_bit) begin
      tx_state_q <= TX_IDLE;
      tx_frame_q <= '1;
      tx_left_q  <= 4'h0;
      tx_ph_q    <= 4'h0;
      tbe_q      <= 1'b1;
      tcm_q      <= 1'b1;
    end else begin
      if (tx_state_q == TX_SHIFT && tick16) tx_ph_q <= tx_ph_q + 4'h1;
      if (bit_end && !last_end) begin
        tx_frame_q <= tx_frame_q >> 1;
        tx_left_q  <= tx_left_q - 4'h1;
      end
      if (tcm_set) begin
        tcm_q      <= 1'b1;
        tx_state_q <= TX_IDLE;
        tx_frame_q <= '1;
      end
      if (buffer_low_byte_wr) tbe_q <= 1'b0;
      if (load) begin
        tx_frame_q <= tx_frame_w;
        tx_left_q  <= tx_len_w;
        tx_ph_q    <= 4'h0;
        tx_state_q <= TX_SHIFT;
        tbe_q      <= 1'b1;
        tcm_q      <= 1'b0;
      end
    end
  end

  // interrupt source picked by the select bit
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tx_irq_q <= 1'b0;
    end else begin
      tx_irq_q <= transmit_interrupt_select ? tcm_set : load;
    end
  end

  assign transmit_data_output = tx_frame_q[0];
  assign transmit_interrupt   = tx_irq_q;

  // ---------------- receive side
  utsc_rx_state_type rx_state_q;
  logic [8:0] rx_shift_q;
  logic [8:0] rx_buf_q;
  logic [8:0] pnd_data_q;
  logic [3:0] rx_cnt_q;
  logic [3:0] rx_need;
  logic       rx_par_q;
  logic       rx_fer_q;
  logic       start_ok;
  logic       bit_ok;
  logic       bit_val;
  logic       rx_last;
  logic       pnd_q;
  logic       pnd_fer_q;
  logic       pnd_per_q;
  logic       apply;
  logic       oer_w;
  logic       err_w;
  logic       rbf_q;
  logic       oer_q;
  logic       fer_q;
  logic       per_q;
  logic       ser_q;
  logic       full_irq_q;
  logic       err_irq_q;
  logic       rts_q;

  assign rx_need = data_len + {3'h0, parity_enable} + 4'h1 + {3'h0, stb};
  assign rx_last = (rx_state_q == RX_FRAME) & bit_ok
                   & (rx_cnt_q == rx_need - 4'h1);

  utsc_rx_smp u_smp (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .line     (rxd_s2_q),
    .tick16   (tick16),
    .enable   (ren & ~receiver_init_bit),
    .stop     (rx_last),
    .start_ok (start_ok),
    .bit_ok   (bit_ok),
    .bit_val  (bit_val)
  );

  // frame assembly; last bit always lands on a stop bit
  always_ff @(posedge clk_sys) begin
    if (reset || receiver_init_bit || !ren) begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q   <= 4'h0;
      rx_shift_q <= 9'h000;
      rx_par_q   <= 1'b0;
      rx_fer_q   <= 1'b0;
    end else if (start_ok) begin
      rx_state_q <= RX_FRAME;
      rx_cnt_q   <= 4'h0;
      rx_shift_q <= 9'h000;
      rx_fer_q   <= 1'b0;
    end else if (rx_state_q == RX_FRAME && bit_ok) begin
      rx_cnt_q <= rx_cnt_q + 4'h1;
      if (rx_cnt_q < data_len) rx_shift_q[rx_cnt_q] <= bit_val;
      else if (parity_enable && rx_cnt_q == data_len) rx_par_q <= bit_val;
      else if (!bit_val) rx_fer_q <= 1'b1;
      if (rx_last) rx_state_q <= RX_IDLE;
    end
  end

  // finished character waits here while status is being read
  always_ff @(posedge clk_sys) begin
    if (reset || receiver_init_bit) begin
      pnd_q      <= 1'b0;
      pnd_fer_q  <= 1'b0;
      pnd_per_q  <= 1'b0;
      pnd_data_q <= 9'h000;
    end else if (rx_last) begin
      pnd_q      <= 1'b1;
      pnd_fer_q  <= rx_fer_q | ~bit_val;
      pnd_per_q  <= parity_enable & (rx_par_q
                    != utsc_parity(rx_shift_q, data_len, parity_select));
      pnd_data_q <= rx_shift_q;
    end else if (apply) begin
      pnd_q <= 1'b0;
    end
  end

  assign apply = pnd_q & ~status_rd;
  assign oer_w = rbf_q | ser_q;
  assign err_w = pnd_fer_q | pnd_per_q | oer_w;

  // receive flags; a late event beats a same-cycle clear
  always_ff @(posedge clk_sys) begin
    if (reset || receiver_init_bit) begin
      rbf_q <= 1'b0;
      oer_q <= 1'b0;
      fer_q <= 1'b0;
      per_q <= 1'b0;
      ser_q <= 1'b0;
    end else begin
      if (status_rd) begin
        oer_q <= 1'b0;
        fer_q <= 1'b0;
        per_q <= 1'b0;
        ser_q <= 1'b0;
      end
      if (buffer_low_byte_rd) rbf_q <= 1'b0;
      if (apply && err_w) begin
        oer_q <= oer_q | oer_w;
        fer_q <= fer_q | pnd_fer_q;
        per_q <= per_q | pnd_per_q;
        ser_q <= 1'b1;
      end else if (apply) begin
        rbf_q <= 1'b1;
      end
    end
  end

  // receive buffer and interrupt pulses
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_buf_q   <= 9'h000;
      full_irq_q <= 1'b0;
      err_irq_q  <= 1'b0;
      rts_q      <= 1'b1;
    end else begin
      if (apply && !err_w && !receiver_init_bit) rx_buf_q <= pnd_data_q;
      full_irq_q <= apply & ~err_w & ~receiver_init_bit;
      err_irq_q  <= apply & err_w & ~receiver_init_bit;
      rts_q <= ~(rts_en & ren & ~receiver_init_bit & (rx_state_q == RX_IDLE));
    end
  end

  assign receive_buffer          = rx_buf_q;
  assign receive_full_interrupt  = full_irq_q;
  assign receive_error_interrupt = err_irq_q;
  assign request_to_send_output  = rts_q;

  // status image; top bit and writes have no effect
  always_comb begin
    serial_status_register          = 8'h00;
    serial_status_register[`ST_TBE] = tbe_q;
    serial_status_register[`ST_TCM] = tcm_q;
    serial_status_register[`ST_RBF] = rbf_q;
    serial_status_register[`ST_OER] = oer_q;
    serial_status_register[`ST_FER] = fer_q;
    serial_status_register[`ST_PER] = per_q;
    serial_status_register[`ST_SER] = ser_q;
  end

  // ---------------- checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_tin_force;
    transmitter_init_bit |=> serial_status_register[`ST_TCM:`ST_TBE] == `TX_INIT_STS;
  endproperty
  a_tin_force: assert property (p_tin_force)
    else $error("transmitter init did not force status 03");

  property p_low_wr;
    buffer_low_byte_wr && !transmitter_init_bit |=> !tbe_q;
  endproperty
  a_low_wr: assert property (p_low_wr)
    else $error("low byte write left buffer empty set");

  property p_rd_clear;
    status_rd |=> !per_q && !ser_q && !fer_q && !oer_q;
  endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("status read did not clear error flags");

  sequence s_read_pend;
    status_rd && pnd_q && !receiver_init_bit ##1 !status_rd && !receiver_init_bit;
  endsequence
  property p_defer;
    s_read_pend |=> !pnd_q;
  endproperty
  a_defer: assert property (p_defer)
    else $error("deferred completion not applied after read");

  property p_load;
    load |=> !transmit_data_output && tbe_q && !tcm_q
             && tx_state_q == TX_SHIFT;
  endproperty
  a_load: assert property (p_load)
    else $error("load did not start frame and update flags");

  property p_frame_hold;
    tx_state_q == TX_SHIFT && tx_left_q > 4'h1 && !transmitter_init_bit
      |=> tx_state_q == TX_SHIFT;
  endproperty
  a_frame_hold: assert property (p_frame_hold)
    else $error("frame cut short");

  property p_tis_irq;
    tcm_set && transmit_interrupt_select |=> transmit_interrupt;
  endproperty
  a_tis_irq: assert property (p_tis_irq)
    else $error("complete interrupt missing");

  property p_err_no_rbf;
    apply && err_w && !rbf_q && !receiver_init_bit |=> !rbf_q && !receive_full_interrupt;
  endproperty
  a_err_no_rbf: assert property (p_err_no_rbf)
    else $error("buffer full set for errored character");
endmodule : utsc_core

// file: utsc_map.svh
// constants for the serial transmitter and receiver core
`ifndef UTSC_MAP_SVH
`define UTSC_MAP_SVH
// control register bits
`define CTL_TEN 0
`define CTL_REN 1
`define CTL_TIN 2
`define CTL_RIN 3
`define CTL_TIS 4
`define CTL_CTS 5
`define CTL_RTS 6
// mode register fields
`define MOD_LEN_LO 0
`define MOD_LEN_HI 1
`define MOD_STB 3
`define MOD_PMD 4
`define MOD_PEN 5
`define MOD_PSC_LO 6
`define MOD_PSC_HI 7
`define LEN_7 2'h0
`define LEN_9 2'h2
// status register bits
`define ST_TBE 0
`define ST_TCM 1
`define ST_RBF 2
`define ST_OER 3
`define ST_FER 4
`define ST_PER 5
`define ST_SER 6
`define TX_INIT_STS 2'h3
// prescaler selections and count masks
`define PSC_X1 2'h0
`define PSC_X8 2'h1
`define PSC_X32 2'h2
`define PSC_M8 8'h07
`define PSC_M32 8'h1F
`define PSC_M256 8'hFF
// oversampling phases
`define SMP_FIRST 4'h7
`define SMP_LAST 4'h9
`define START_MIN 4'h2
`define PHASE_LAST 4'hF
`endif

// file: utsc_pkg.sv
// types and shared functions of the serial core
package utsc_pkg;
`include "utsc_map.svh"
  typedef enum logic [2:0] {
    SMP_IDLE = 3'b001,
    SMP_HUNT = 3'b010,
    SMP_RUN  = 3'b100
  } utsc_smp_state_type;
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b01,
    TX_SHIFT = 2'b10
  } utsc_tx_state_type;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b01,
    RX_FRAME = 2'b10
  } utsc_rx_state_type;

  // two of three vote
  function automatic logic utsc_major3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : utsc_major3

  // data bits per character
  function automatic logic [3:0] utsc_data_len(input logic [1:0] sel);
    if (sel == `LEN_7) return 4'h7;
    if (sel == `LEN_9) return 4'h9;
    return 4'h8;
  endfunction : utsc_data_len

  // expected parity bit; even selects even parity
  function automatic logic utsc_parity(input logic [8:0] d,
                                       input logic [3:0] len,
                                       input logic       even);
    logic p;
    p = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < len) p = p ^ d[i];
    end
    return even ? p : ~p;
  endfunction : utsc_parity
endpackage : utsc_pkg

// file: utsc_baud.sv
// prescaler and baud divider giving the 16x basic clock tick
`timescale 1ns/1ns
`include "utsc_map.svh"
module utsc_baud import utsc_pkg::*; (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // settings
  input  wire logic [1:0] psc_sel,
  input  wire logic [7:0] divisor,
  // tick out
  output logic            tick16
);
  logic [7:0] psc_q;
  logic [7:0] div_q;
  logic       tick_q;
  logic       pre_tick;
  logic       div_wrap;

  // prescaler taps chosen by the mode field
  assign pre_tick = (psc_sel == `PSC_X1)
    | ((psc_sel == `PSC_X8) & ((psc_q & `PSC_M8) == `PSC_M8))
    | ((psc_sel == `PSC_X32) & ((psc_q & `PSC_M32) == `PSC_M32))
    | ((psc_sel > `PSC_X32) & (psc_q == `PSC_M256));
  assign div_wrap = pre_tick & (div_q == divisor);
  assign tick16   = tick_q;

  // divide by divisor plus one
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      psc_q  <= 8'h00;
      div_q  <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      psc_q  <= psc_q + 8'h01;
      tick_q <= div_wrap;
      if (pre_tick) div_q <= div_wrap ? 8'h00 : div_q + 8'h01;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_tick_spacing;
    tick16 && divisor != 8'h00 && $stable(divisor) |=> !tick16;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("basic tick came faster than divisor allows");
endmodule : utsc_baud

// file: utsc_rx_smp.sv
// start detection and three-sample majority of receive bits
`timescale 1ns/1ns
`include "utsc_map.svh"
module utsc_rx_smp import utsc_pkg::*; (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // line and timing
  input  wire logic line,
  input  wire logic tick16,
  input  wire logic enable,
  input  wire logic stop,
  // results
  output logic      start_ok,
  output logic      bit_ok,
  output logic      bit_val
);
  utsc_smp_state_type state_q;
  logic [3:0] phase_q;
  logic [2:0] smp_q;
  logic       prev_q;
  logic       start_q;
  logic       bitok_q;
  logic       bitval_q;
  logic       fall;
  logic       at_smp;
  logic       at_dec;
  logic       early_hi;
  logic       vote;

  // line is already synchronised by the caller
  assign fall     = prev_q & ~line;
  assign at_smp   = tick16 & (phase_q >= `SMP_FIRST)
                    & (phase_q <= `SMP_LAST);
  assign at_dec   = tick16 & (phase_q == `SMP_LAST);
  assign early_hi = tick16 & line & (phase_q < `START_MIN);
  assign vote     = utsc_major3({smp_q[1:0], line});
  assign start_ok = start_q;
  assign bit_ok   = bitok_q;
  assign bit_val  = bitval_q;

  // hunting, then per-bit decisions every 16 ticks
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q  <= SMP_IDLE;
      phase_q  <= 4'h0;
      smp_q    <= 3'h7;
      prev_q   <= 1'b1;
      start_q  <= 1'b0;
      bitok_q  <= 1'b0;
      bitval_q <= 1'b1;
    end else begin
      prev_q  <= line;
      start_q <= 1'b0;
      bitok_q <= 1'b0;
      if (tick16 && state_q != SMP_IDLE) phase_q <= phase_q + 4'h1;
      if (at_smp) smp_q <= {smp_q[1:0], line};
      unique case (state_q)
        SMP_IDLE: begin
          if (enable && fall) begin
            state_q <= SMP_HUNT;
            phase_q <= 4'h0;
          end
        end
        SMP_HUNT: begin
          if (!enable || early_hi) begin
            state_q <= SMP_IDLE;
          end else if (at_dec) begin
            state_q <= vote ? SMP_IDLE : SMP_RUN;
            start_q <= ~vote;
          end
        end
        SMP_RUN: begin
          if (!enable || stop) begin
            state_q <= SMP_IDLE;
          end else if (at_dec) begin
            bitok_q  <= 1'b1;
            bitval_q <= vote;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_short_low;
    state_q == SMP_HUNT && early_hi |=> state_q == SMP_IDLE;
  endproperty
  a_short_low: assert property (p_short_low)
    else $error("short low pulse not rejected");

  property p_start_vote;
    state_q == SMP_HUNT && enable && !early_hi && at_dec && vote
      |=> state_q == SMP_IDLE && !start_ok;
  endproperty
  a_start_vote: assert property (p_start_vote)
    else $error("start accepted without a low majority");
endmodule : utsc_rx_smp

// file: utsc_peer.sv
// remote serial peer: sends frames and catches transmitted bytes
`timescale 1ns/1ns
module utsc_peer (
  // clock
  input  wire logic clk_sys,
  // serial pins
  output logic      rxd_line,
  input  wire logic txd_line
);
  // divisor 0 with x1 prescale gives 16 clocks a bit
  localparam int BIT_CLKS = 16;

  // line idles at mark level
  initial rxd_line = 1'b1;

  // frame bits lsb first, start bit included
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      rxd_line <= bits[i];
      repeat (BIT_CLKS - 1) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    rxd_line <= 1'b1;
  endtask : send

  // low glitch of n clocks, shorter than a bit time
  task automatic pulse(input int n);
    @(posedge clk_sys);
    rxd_line <= 1'b0;
    repeat (n) @(posedge clk_sys);
    rxd_line <= 1'b1;
  endtask : pulse

  // mid-bit sampling; bounded wait for a start bit
  task automatic catch_byte(output logic [7:0] d, output logic stop);
    int w;
    w = 0;
    while (txd_line !== 1'b0 && w < 3000) begin
      @(posedge clk_sys);
      w++;
    end
    repeat (BIT_CLKS / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk_sys);
      d[i] = txd_line;
    end
    repeat (BIT_CLKS) @(posedge clk_sys);
    stop = txd_line;
  endtask : catch_byte
endmodule : utsc_peer

// file: utsc_core_test.sv
// self-checking bench of the serial core against the peer model
`timescale 1ns/1ns
module utsc_core_test;
  logic       clk_sys = 1'b0;
  logic       reset   = 1'b1;
  logic [6:0] ctl     = 7'h0C;
  logic [7:0] mode    = 8'h01;
  logic [7:0] brg     = 8'h00;
  logic       wr_lo   = 1'b0;
  logic       wr_hi   = 1'b0;
  logic       rd_lo   = 1'b0;
  logic       st_rd   = 1'b0;
  logic       d_hi    = 1'b0;
  logic       cts_n   = 1'b0;
  logic [7:0] d_lo    = 8'h00;
  logic [7:0] sts, v, got_a, got_b;
  logic [8:0] rbuf;
  logic       txd, rxd, v_stop;
  logic       txi, rfi, rei, rts_n;
  logic [7:0] n_txi = 8'h00;
  logic [7:0] n_rfi = 8'h00;
  logic [7:0] n_rei = 8'h00;
  int         n_mismatch = 0;
  int         n_checks   = 0;

  always #2 clk_sys = ~clk_sys;

  utsc_core i_dut (.clk_sys(clk_sys), .reset(reset),
    .serial_control_register(ctl), .serial_mode_register(mode),
    .baud_rate_generator(brg), .buffer_low_byte_wr(wr_lo),
    .buffer_low_byte_in(d_lo), .buffer_high_byte_wr(wr_hi),
    .buffer_high_byte_in(d_hi), .buffer_low_byte_rd(rd_lo),
    .status_rd(st_rd), .receive_buffer(rbuf),
    .serial_status_register(sts), .transmit_interrupt(txi),
    .receive_full_interrupt(rfi), .receive_error_interrupt(rei),
    .receive_data_input(rxd), .clear_to_send_input(cts_n),
    .transmit_data_output(txd), .request_to_send_output(rts_n));
  utsc_peer i_peer (.clk_sys(clk_sys), .rxd_line(rxd), .txd_line(txd));

  // one-cycle interrupt pulses counted; held off in reset while flops are x
  always @(posedge clk_sys) begin
    if (!reset) begin
      n_txi <= n_txi + {7'h00, txi};
      n_rfi <= n_rfi + {7'h00, rfi};
      n_rei <= n_rei + {7'h00, rei};
    end
  end

  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  // high byte first, since the low write queues the character
  task automatic put_char(input logic [8:0] c);
    @(posedge clk_sys);
    wr_hi <= 1'b1;
    d_hi  <= c[8];
    @(posedge clk_sys);
    wr_hi <= 1'b0;
    wr_lo <= 1'b1;
    d_lo  <= c[7:0];
    @(posedge clk_sys);
    wr_lo <= 1'b0;
  endtask : put_char

  // status sampled while the read is in progress
  task automatic read_sts(output logic [7:0] s);
    @(posedge clk_sys);
    st_rd <= 1'b1;
    #1 s = sts;
    @(posedge clk_sys);
    st_rd <= 1'b0;
  endtask : read_sts

  // a frame plus time for the deferred flag update
  task automatic rx_frame(input logic [11:0] bits, input int n);
    i_peer.send(bits, n);
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : rx_frame

  // hang guard, several times the expected run
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    report_and_stop();
  end

  // main sequence; baud value set before any enable
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    #1 check(sts, 9'h003);
    check(txd, 1'b1);
    check(rts_n, 1'b1);
    @(posedge clk_sys);
    ctl <= 7'h03;
    fork
      begin put_char(9'h0A5); put_char(9'h05A); end
      begin
        i_peer.catch_byte(got_a, v_stop);
        i_peer.catch_byte(got_b, v_stop);
      end
    join
    check(got_a, 9'h0A5);
    check(got_b, 9'h05A);
    repeat (20) @(posedge clk_sys);
    #1 check(sts[1:0], 2'h3);
    check(n_txi, 8'h02);
    // handshake holds the load while clear-to-send is high
    @(posedge clk_sys);
    ctl   <= 7'h23;
    cts_n <= 1'b1;
    put_char(9'h00F);
    repeat (40) @(posedge clk_sys);
    #1 check(sts[1:0], 2'h2);
    check(txd, 1'b1);
    @(posedge clk_sys);
    ctl <= 7'h27;
    repeat (3) @(posedge clk_sys);
    #1 check(sts[1:0], 2'h3);
    @(posedge clk_sys);
    ctl <= 7'h33;
    put_char(9'h0C3);
    fork
      begin repeat (8) @(posedge clk_sys); cts_n <= 1'b0; end
      i_peer.catch_byte(got_a, v_stop);
    join
    check(got_a, 9'h0C3);
    check(v_stop, 1'b1);
    check(n_txi, 8'h02);
    // clean character, then an unread one overruns
    rx_frame({2'b11, 8'h3C, 1'b0}, 10);
    check(sts[2], 1'b1);
    check(rbuf, 9'h03C);
    rx_frame({2'b11, 8'h81, 1'b0}, 10);
    check(rbuf, 9'h03C);
    read_sts(v);
    check(v[6:2], 5'h13);
    @(posedge clk_sys);
    rd_lo <= 1'b1;
    @(posedge clk_sys);
    rd_lo <= 1'b0;
    #1 check(sts[6:3], 4'h0);
    check(sts[2], 1'b0);
    // even parity, wrong parity bit sent
    @(posedge clk_sys);
    mode <= 8'h31;
    rx_frame({2'b11, 1'b1, 8'h55, 1'b0}, 11);
    check(sts[6:2], 5'h18);
    read_sts(v);
    // stop bit low while a status read is held
    @(posedge clk_sys);
    mode <= 8'h01;
    fork
      rx_frame({2'b10, 8'hF0, 1'b0}, 10);
      begin repeat (150) @(posedge clk_sys); st_rd <= 1'b1; end
    join
    check(sts[4], 1'b0);
    @(posedge clk_sys);
    st_rd <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 check(sts[4], 1'b1);
    read_sts(v);
    check(v[6:2], 5'h14);
    // 9-bit, two stop bits, rts handshake, glitches first
    @(posedge clk_sys);
    mode <= 8'h0A;
    ctl  <= 7'h43;
    repeat (2) @(posedge clk_sys);
    #1 check(rts_n, 1'b0);
    i_peer.pulse(1);
    repeat (20) @(posedge clk_sys);
    i_peer.pulse(6);
    repeat (200) @(posedge clk_sys);
    #1 check(sts[2], 1'b0);
    rx_frame({1'b1, 1'b1, 9'h1A5, 1'b0}, 12);
    check(sts[6:2], 5'h01);
    check(rbuf, 9'h1A5);
    check(n_rfi, 8'h02);
    check(n_rei, 8'h03);
    check(n_txi, 8'h03);
    // slower divisor while idle keeps the tick spacing check live
    @(posedge clk_sys);
    ctl <= 7'h0C;
    brg <= 8'h01;
    repeat (40) @(posedge clk_sys);
    report_and_stop();
  end
endmodule : utsc_core_test
